// ===== verilog/supply_low_voltage_monitor.v
// Supply low-voltage monitor: control register, delayed interrupt and wake-up
// Operation
// - Bits 7,6,3 read zero, ignore writes
// - Bit 5 is read-only low-supply flag
// - Bit 4 switches detector on or off
// - Bits 2..0 select one of eight thresholds
// - Flag follows detector output directly
// - Interrupt request only after fixed delay; code also sets it at once on a bus write of 1 to the request bit
// - Request feeds shared multi-function interrupt
// - Monitor runs asleep and wakes device
// - Already-pending request cannot wake device
// - Disabled or stack full: resume after stop
// - Enabled with stack room: normal interrupt response
// - Only stop instruction enters sleep, holds state; code also sleeps on a bus write of SM_SLEEP_CMD to the sleep register
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "supply_monitor_defines.vh"
module supply_low_voltage_monitor (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// AHB-Lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Analog detector
	input wire detector_low,
	output reg supply_monitor_on,
	output reg [2:0] threshold_select,
	// Core side
	input wire stop_exec,
	input wire stack_full,
	output reg supply_monitor_irq_request,
	output reg multi_irq,
	output reg core_asleep,
	output reg wake_resume,
	output reg wake_vector
);
	// Wake-up sequencer states
	localparam [2:0] st_run = 3'b001;
	localparam [2:0] st_sleep = 3'b010;
	localparam [2:0] st_wake = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;
	reg low_supply_flag;
	reg irq_enable;
	reg [`SM_DLY_W-1:0] dly_cnt;
	reg dly_done;
	reg wr_pend;
	reg [11:0] wr_addr;
	reg wake_block;
	wire det_sync;
	wire addr_phase;
	wire stop_req;
	wire irq_set;
	wire [7:0] ctl_word;
	wire [1:0] irq_word;
	wire [1:0] status_word;
	wire wr_ctl;
	wire wr_irq;
	wire wr_sleep;
	wire rd_req;
	wire room_for_vector;
	wire [31:0] dly_last_full;
	wire [`SM_DLY_W-1:0] dly_last;
	reg [31:0] next_hrdata;
	reg next_wr_pend;
	reg next_supply_monitor_on;
	reg [2:0] next_threshold_select;
	reg next_irq_enable;
	reg next_irq_request;
	reg next_low_supply_flag;
	reg [`SM_DLY_W-1:0] next_dly_cnt;
	reg next_dly_done;
	reg next_wake_block;
	reg next_core_asleep;
	reg next_wake_resume;
	reg next_wake_vector;
	reg next_multi_irq;

	// Helper: match a byte address, live or latched, to a register offset
	function sel_reg;
		input [11:0] a;
		input [11:0] ofs;
		begin
			sel_reg = (a[11:2] == ofs[11:2]);
		end
	endfunction

	// Read multiplexer over the control, interrupt and status words; the sleep word and holes read zero
	function [31:0] read_word;
		input [11:0] a;
		input [7:0] ctl;
		input [1:0] irq;
		input [1:0] st;
		begin
			read_word = 32'h0000_0000;
			if (sel_reg(a, `SM_OFS_CONTROL))
				read_word = {24'h00_0000, ctl};
			else if (sel_reg(a, `SM_OFS_IRQ))
				read_word = {30'h0, irq};
			else if (sel_reg(a, `SM_OFS_STATUS))
				read_word = {30'h0, st};
		end
	endfunction

	level_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in(detector_low),
		.sync_out(det_sync)
	);

	assign addr_phase = hsel & hready & htrans[1];
	assign stop_req = stop_exec | (wr_sleep & (hwdata[7:0] == `SM_SLEEP_CMD));
	// Write strobes for the data phase of a latched write
	assign wr_ctl = wr_pend & sel_reg(wr_addr, `SM_OFS_CONTROL);
	assign wr_irq = wr_pend & sel_reg(wr_addr, `SM_OFS_IRQ);
	assign wr_sleep = wr_pend & sel_reg(wr_addr, `SM_OFS_SLEEP);
	assign rd_req = addr_phase & ~hwrite;
	assign room_for_vector = irq_enable & ~stack_full;
	assign irq_word = {irq_enable, supply_monitor_irq_request};
	assign status_word = {stack_full, core_asleep};
	// Delay end count, cut on purpose to the counter width
	assign dly_last_full = `SM_IRQ_DELAY_CYC - 1;
	assign dly_last = dly_last_full[`SM_DLY_W-1:0];
	assign irq_set = low_supply_flag & dly_done;
	assign ctl_word = {2'b00, low_supply_flag, supply_monitor_on, 1'b0, threshold_select};

	// Bus next values: zero wait states, always OKAY
	always @* begin
		next_wr_pend = addr_phase & hwrite;
		next_hrdata = hrdata;
		// Data held until the next read, not cleared on idle cycles
		if (rd_req)
			next_hrdata = read_word(haddr, ctl_word, irq_word, status_word);
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= next_wr_pend;
			wr_addr <= haddr;
			hrdata <= next_hrdata;
		end
	end

	// Next values of the control and interrupt registers
	always @* begin
		next_supply_monitor_on = supply_monitor_on;
		next_threshold_select = threshold_select;
		next_irq_enable = irq_enable;
		next_irq_request = supply_monitor_irq_request;
		if (wr_ctl) begin
			next_supply_monitor_on = hwdata[`SM_CTL_ON_BIT];
			next_threshold_select = hwdata[`SM_CTL_THR_HI:`SM_CTL_THR_LO];
		end
		if (wr_irq) begin
			next_irq_enable = hwdata[`SM_IRQ_EN_BIT];
			// software may set or clear request
			next_irq_request = hwdata[`SM_IRQ_REQ_BIT];
		end
		// request set even while asleep
		// Set wins over a clearing write so no event is lost
		if (irq_set)
			next_irq_request = 1'b1;
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			supply_monitor_on <= 1'b0;
			threshold_select <= 3'b000;
			irq_enable <= 1'b0;
			supply_monitor_irq_request <= 1'b0;
		end else begin
			supply_monitor_on <= next_supply_monitor_on;
			threshold_select <= next_threshold_select;
			irq_enable <= next_irq_enable;
			supply_monitor_irq_request <= next_irq_request;
		end
	end

	// Flag and delay counter; the counter restarts on every flag fall
	always @* begin
		next_low_supply_flag = det_sync & supply_monitor_on;
		next_dly_cnt = dly_cnt;
		next_dly_done = dly_done;
		if (~low_supply_flag) begin
			next_dly_cnt = {`SM_DLY_W{1'b0}};
			next_dly_done = 1'b0;
		end else if (dly_cnt == dly_last) begin
			next_dly_done = 1'b1;
		end else begin
			next_dly_cnt = dly_cnt + 1'b1;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_supply_flag <= 1'b0;
			dly_cnt <= {`SM_DLY_W{1'b0}};
			dly_done <= 1'b0;
		end else begin
			low_supply_flag <= next_low_supply_flag;
			dly_cnt <= next_dly_cnt;
			dly_done <= next_dly_done;
		end
	end

	// Wake-up sequencer
	always @* begin
		next_state = state;
		case (state)
			st_run: begin
				if (stop_req)
					next_state = st_sleep;
			end
			st_sleep: begin
				if (supply_monitor_irq_request & ~wake_block)
					next_state = st_wake;
			end
			st_wake: next_state = st_run;
			default: next_state = st_run;
		endcase
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= st_run;
			wake_block <= 1'b0;
			core_asleep <= 1'b0;
			wake_resume <= 1'b0;
			wake_vector <= 1'b0;
			multi_irq <= 1'b0;
		end else begin
			state <= next_state;
			wake_block <= next_wake_block;
			core_asleep <= next_core_asleep;
			wake_resume <= next_wake_resume;
			wake_vector <= next_wake_vector;
			multi_irq <= next_multi_irq;
		end
	end

	// Sequencer outputs; wake kinds are one-cycle pulses
	always @* begin
		next_wake_block = wake_block;
		next_wake_resume = 1'b0;
		next_wake_vector = 1'b0;
		// Block latched at entry, released once request clears asleep
		if (state == st_run && stop_req)
			next_wake_block = supply_monitor_irq_request;
		else if (state == st_sleep && ~supply_monitor_irq_request)
			next_wake_block = 1'b0;
		next_core_asleep = (next_state == st_sleep);
		if (state == st_sleep && next_state == st_wake) begin
			next_wake_vector = room_for_vector;
			next_wake_resume = ~room_for_vector;
		end
		next_multi_irq = supply_monitor_irq_request & room_for_vector & (next_state != st_sleep);
	end
endmodule // supply_low_voltage_monitor

// ===== verilog/supply_monitor_defines.vh
// Offsets, fields, reset values and timing counts of the supply monitor
`ifndef SUPPLY_MONITOR_DEFINES_VH
`define SUPPLY_MONITOR_DEFINES_VH
`define SM_CLK_PERIOD_NS 10
// Byte offsets on the register bus
`define SM_OFS_CONTROL 12'h000
`define SM_OFS_IRQ 12'h004
`define SM_OFS_SLEEP 12'h008
`define SM_OFS_STATUS 12'h00C
// Control register fields
`define SM_CTL_FLAG_BIT 5
`define SM_CTL_ON_BIT 4
`define SM_CTL_THR_HI 2
`define SM_CTL_THR_LO 0
`define SM_CTL_WRITE_MASK 8'h17
`define SM_CTL_RESET 8'h00
// Interrupt register fields
`define SM_IRQ_REQ_BIT 0
`define SM_IRQ_EN_BIT 1
`define SM_IRQ_RESET 8'h00
// Status register fields
`define SM_ST_ASLEEP_BIT 0
`define SM_ST_STACK_FULL_BIT 1
// Sleep command value
`define SM_SLEEP_CMD 8'h01
// Interrupt delay, in ns and in cycles (rounded up)
`define SM_IRQ_DELAY_NS 1000
`define SM_IRQ_DELAY_CYC ((`SM_IRQ_DELAY_NS + `SM_CLK_PERIOD_NS - 1) / `SM_CLK_PERIOD_NS)
`define SM_DLY_W 8
`endif

// ===== verilog/level_sync.v
// Two-stage synchroniser for the detector output
`timescale 1ns/100ps
module level_sync (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Levels
	input wire async_in,
	output reg sync_out
);
	reg stage1;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // level_sync

// ===== testbench/supply_low_voltage_monitor_chk.sv
// Port assertions for the supply monitor
`timescale 1ns/100ps
module slvm_chk (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Core and detector side
	input wire detector_low,
	input wire stop_exec,
	input wire stack_full,
	input wire supply_monitor_irq_request,
	input wire multi_irq,
	input wire core_asleep,
	input wire wake_resume,
	input wire wake_vector
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	wake_on_req_a: assert property (
		core_asleep && $rose(supply_monitor_irq_request) |-> ##[0:2] (wake_resume || wake_vector)) else $error("no wake");
	pend_blocks_a: assert property (
		stop_exec && !core_asleep && supply_monitor_irq_request |=> core_asleep [*4]) else $error("pending woke");
	sleep_entry_a: assert property (
		stop_exec && !core_asleep |=> core_asleep) else $error("no sleep");
	wake_leaves_a: assert property (
		wake_resume || wake_vector |-> $past(core_asleep) ##1 !core_asleep) else $error("bad wake");
	vec_room_a: assert property (
		wake_vector |-> !$past(stack_full)) else $error("vector when full");
	wake_once_a: assert property (
		wake_resume || wake_vector |=> !(wake_resume || wake_vector)) else $error("long wake");
	shared_irq_a: assert property (
		$rose(multi_irq) |-> supply_monitor_irq_request && !$past(stack_full)) else $error("bad irq");
	irq_delay_a: assert property (
		core_asleep && $rose(supply_monitor_irq_request) |-> $past(detector_low, 100)) else $error("early req");
endmodule // slvm_chk
bind supply_low_voltage_monitor slvm_chk chk_u (.*);

// ===== testbench/supply_low_voltage_monitor_tb.sv
// Bus-driven tests of the supply monitor
`timescale 1ns/100ps
`include "supply_monitor_defines.vh"
module supply_low_voltage_monitor_tb;
	reg mclk = 0, rst = 1, hsel = 0, hwrite = 0, hready = 1;
	reg detector_low = 0, stop_exec = 0, stack_full = 0;
	reg [11:0] haddr = 12'h000;
	reg [1:0] htrans = 2'h0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0000_0000, rd;
	wire [31:0] hrdata;
	wire [2:0] threshold_select;
	wire hreadyout, hresp, supply_monitor_on, supply_monitor_irq_request;
	wire multi_irq, core_asleep, wake_resume, wake_vector;
	int failures = 0, n_checks = 0, i;
	always #5 mclk = ~mclk;
	supply_low_voltage_monitor dut_u (
		.mclk(mclk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.detector_low(detector_low),
		.supply_monitor_on(supply_monitor_on),
		.threshold_select(threshold_select),
		.stop_exec(stop_exec),
		.stack_full(stack_full),
		.supply_monitor_irq_request(supply_monitor_irq_request),
		.multi_irq(multi_irq),
		.core_asleep(core_asleep),
		.wake_resume(wake_resume),
		.wake_vector(wake_vector)
	);
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Bounded wait for the slave's ready
	task hold;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i == 50) begin
			failures++;
			wrap_up;
		end
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hold;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		rd = hrdata;
	endtask
	task wake(input [1:0] exp);
		i = 0;
		while (!(wake_resume | wake_vector) && i < 300) begin
			@(posedge mclk);
			i++;
		end
		chk({wake_resume, wake_vector}, exp, "wake kind");
		if (i == 300) begin
			failures++;
			wrap_up;
		end
	endtask
	initial begin
		cyc(2);
		rst <= 1'b0;
		xfer(0, `SM_OFS_CONTROL, 0);
		chk(rd, `SM_CTL_RESET, "ctl reset");
		chk(hreadyout, 1, "ready");
		chk(hresp, 0, "okay");
		for (int t = 0; t < 8; t++) begin
			xfer(1, `SM_OFS_CONTROL, 32'h0000_00F8 | t);
			xfer(0, `SM_OFS_CONTROL, 0);
			chk(rd, 32'h0000_0010 | t, "ctl");
			chk(threshold_select, t, "thr");
			chk(supply_monitor_on, 1, "on");
		end
		xfer(0, 12'h010, 0);
		chk(rd, 0, "unmapped");
		$display("register test done");
		detector_low <= 1'b1;
		cyc(5);
		xfer(0, `SM_OFS_CONTROL, 0);
		chk(rd, 32'h0000_0037, "flag set");
		detector_low <= 1'b0;
		cyc(5);
		xfer(0, `SM_OFS_CONTROL, 0);
		chk(rd, 32'h0000_0017, "flag clear");
		$display("flag test done");
		xfer(1, `SM_OFS_IRQ, 32'h0000_0002);
		detector_low <= 1'b1;
		cyc(90);
		chk(supply_monitor_irq_request, 0, "req early");
		cyc(25);
		chk(supply_monitor_irq_request, 1, "req");
		chk(multi_irq, 1, "shared irq");
		$display("delay test done");
		xfer(1, `SM_OFS_IRQ, 32'h0000_0003);
		xfer(0, `SM_OFS_IRQ, 0);
		chk(rd, 32'h0000_0003, "irq reg");
		@(posedge mclk);
		stop_exec <= 1'b1;
		@(posedge mclk);
		stop_exec <= 1'b0;
		cyc(5);
		chk(core_asleep, 1, "pending sleep");
		chk(multi_irq, 0, "irq asleep");
		detector_low <= 1'b0;
		cyc(5);
		xfer(1, `SM_OFS_IRQ, 32'h0000_0002);
		detector_low <= 1'b1;
		wake(2'b01);
		$display("vector wake test done");
		detector_low <= 1'b0;
		stack_full <= 1'b1;
		cyc(5);
		xfer(1, `SM_OFS_IRQ, 32'h0000_0002);
		xfer(1, `SM_OFS_SLEEP, `SM_SLEEP_CMD);
		cyc(2);
		chk(core_asleep, 1, "sleep");
		detector_low <= 1'b1;
		wake(2'b10);
		cyc(2);
		chk(multi_irq, 0, "irq full");
		xfer(0, `SM_OFS_STATUS, 0);
		chk(rd, 32'h0000_0002, "status");
		$display("resume wake test done");
		xfer(1, `SM_OFS_CONTROL, 0);
		cyc(5);
		chk(supply_monitor_on, 0, "off");
		xfer(0, `SM_OFS_CONTROL, 0);
		chk(rd, 0, "flag off");
		$display("off test done");
		wrap_up;
	end
endmodule // supply_low_voltage_monitor_tb
